// ### rtl/rwsup_top.sv
// module: reset and wakeup supervisor with watchdog monitor
`timescale 1ns/10ps
`default_nettype none
module rwsup_top #(
    parameter logic [31:0] PERIOD_CYC = 32'(rwsup_pkg::PERIOD_CYC)
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic enable,
    input wire logic supply_input_ok,
    input wire logic regulated_output_ok,
    input wire logic watchdog_kick_input,
    output logic reset_n,
    output logic wakeup,
    output logic regulator_on
);
    // ************************************************************
    // input conditioning
    // ************************************************************
    logic kick_fall;
    logic sup_ok;
    logic out_ok;
    logic en_lvl;
    rwsup_edge_det u_kick (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(watchdog_kick_input),
        .level(),
        .fall(kick_fall)
    );
    rwsup_edge_det u_sup (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(supply_input_ok),
        .level(sup_ok),
        .fall()
    );
    rwsup_edge_det u_out (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(regulated_output_ok),
        .level(out_ok),
        .fall()
    );
    rwsup_edge_det u_en (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(enable),
        .level(en_lvl),
        .fall()
    );

    // ************************************************************
    // derived timing counts
    // ************************************************************
    logic [31:0] delay_cyc;
    logic [31:0] wake_dly_cyc;
    logic [31:0] half_cyc;
    assign delay_cyc = PERIOD_CYC >> 3;
    assign wake_dly_cyc = PERIOD_CYC >> 1;
    assign half_cyc = PERIOD_CYC >> 1;

    // ************************************************************
    // supervisor state machine
    // ************************************************************
    rwsup_pkg::rwsup_state_t st_q;
    rwsup_pkg::rwsup_state_t st_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic kicked_q;
    logic kicked_d;
    logic [2:0] pulse_q;
    logic [2:0] pulse_d;
    logic fault;
    logic cnt_end;
    logic cyc_end;
    logic missed;
    logic wake_lvl;
    // supply or output fault, or enable low, forces the hold state
    assign fault = ~en_lvl | ~sup_ok | ~out_ok;
    assign cnt_end = (cnt_q == 32'h0);
    assign cyc_end = (st_q == rwsup_pkg::RWSUP_ST_RUN) && (cnt_q == PERIOD_CYC - 32'h1);
    assign missed = cyc_end & ~kicked_q & ~kick_fall;
    // high for the first half of each cycle unless already kicked
    assign wake_lvl = (cnt_q < half_cyc) & ~kicked_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        kicked_d = kicked_q;
        pulse_d = pulse_q;
        if (fault) begin
            st_d = rwsup_pkg::RWSUP_ST_HOLD;
            cnt_d = 32'h0;
            kicked_d = 1'b0;
            pulse_d = 3'h0;
        end else begin
            unique case (st_q)
                rwsup_pkg::RWSUP_ST_HOLD: begin
                    // output back in regulation: start a full delay
                    st_d = rwsup_pkg::RWSUP_ST_DELAY;
                    cnt_d = delay_cyc;
                end
                rwsup_pkg::RWSUP_ST_DELAY: begin
                    // watchdog reset pulse is timed by the pulse counter
                    if (pulse_q != 3'h0) begin
                        pulse_d = pulse_q - 3'h1;
                    end else if (cnt_end) begin
                        st_d = rwsup_pkg::RWSUP_ST_WAKE_DLY;
                        cnt_d = wake_dly_cyc;
                    end else begin
                        cnt_d = cnt_q - 32'h1;
                    end
                end
                rwsup_pkg::RWSUP_ST_WAKE_DLY: begin
                    if (cnt_end) begin
                        st_d = rwsup_pkg::RWSUP_ST_RUN;
                        cnt_d = 32'h0;
                        kicked_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q - 32'h1;
                    end
                end
                rwsup_pkg::RWSUP_ST_RUN: begin
                    // only the first kick in a cycle counts
                    if (kick_fall & ~kicked_q) begin
                        kicked_d = 1'b1;
                    end
                    // pulse first, then a full reset delay before reset releases
                    if (missed) begin
                        st_d = rwsup_pkg::RWSUP_ST_DELAY;
                        pulse_d = 3'(rwsup_pkg::WD_PULSE_CYC);
                        cnt_d = delay_cyc;
                        kicked_d = 1'b0;
                    end else if (cyc_end) begin
                        cnt_d = 32'h0;
                        kicked_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q + 32'h1;
                    end
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= rwsup_pkg::RWSUP_ST_HOLD;
            cnt_q <= 32'h0;
            kicked_q <= 1'b0;
            pulse_q <= 3'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            kicked_q <= kicked_d;
            pulse_q <= pulse_d;
        end
    end

    // ************************************************************
    // outputs, registered
    // ************************************************************
    logic run_d;
    assign run_d = (st_d == rwsup_pkg::RWSUP_ST_WAKE_DLY) || (st_d == rwsup_pkg::RWSUP_ST_RUN);
    // wakeup never rises while reset is low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reset_n <= 1'b0;
            wakeup <= 1'b0;
            regulator_on <= 1'b0;
        end else begin
            reset_n <= run_d;
            wakeup <= (st_q == rwsup_pkg::RWSUP_ST_RUN) & ~fault & wake_lvl & ~missed
                & ~(kick_fall & ~kicked_q);
            regulator_on <= en_lvl;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_wake_in_reset: assert property (@(posedge clk_sys) disable iff (rst)
        !reset_n |-> !wakeup) else $error("wakeup high while reset low");
    a_fault_resets: assert property (@(posedge clk_sys) disable iff (rst)
        fault |=> !reset_n) else $error("fault did not assert reset");
    a_kick_drops_wake: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q == rwsup_pkg::RWSUP_ST_RUN && kick_fall && !fault) |=> !wakeup)
        else $error("kick did not force wakeup low");
    a_missed_resets: assert property (@(posedge clk_sys) disable iff (rst)
        (missed && !fault) |=> !reset_n [*4]) else $error("missed kick reset pulse wrong");
    a_kick_keeps_run: assert property (@(posedge clk_sys) disable iff (rst)
        (cyc_end && kicked_q && !fault) |=> reset_n) else $error("kicked cycle caused reset");
    a_release_wake_low: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(reset_n) |-> !wakeup) else $error("wakeup high at reset release");
    a_recover_delay: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q == rwsup_pkg::RWSUP_ST_HOLD && !fault) |=> !reset_n [*2])
        else $error("reset released without delay");
    a_enable_off: assert property (@(posedge clk_sys) disable iff (rst)
        !en_lvl |=> (st_q == rwsup_pkg::RWSUP_ST_HOLD)) else $error("enable low did not hold");
    c_wake_rise: cover property (@(posedge clk_sys) disable iff (rst) $rose(wakeup));
    c_kick_ok: cover property (@(posedge clk_sys) disable iff (rst) cyc_end && kicked_q);
    c_missed: cover property (@(posedge clk_sys) disable iff (rst) missed);
endmodule
`default_nettype wire

// ### shared/rwsup_pkg.sv
// package: timing constants and states for the reset and wakeup supervisor
package rwsup_pkg;
    // timing resistor scale factors, in picoseconds per ohm
    localparam int unsigned PERIOD_PS_PER_OHM = 417000;
    localparam int unsigned DELAY_PS_PER_OHM = 52100;
    localparam int unsigned WAKE_DLY_PS_PER_OHM = 208000;
    // default timing resistor in ohms
    localparam int unsigned RDELAY_OHM = 60000;
    // clock period in picoseconds (40 MHz)
    localparam int unsigned CLK_PERIOD_PS = 25000;
    // wakeup period in clock cycles for the default resistor
    localparam longint unsigned PERIOD_CYC_L =
        (longint'(PERIOD_PS_PER_OHM) * longint'(RDELAY_OHM)) / longint'(CLK_PERIOD_PS);
    localparam int unsigned PERIOD_CYC = int'(PERIOD_CYC_L);
    // counter width
    localparam int unsigned CNT_W = 32;
    // reset pulse length after a missed kick, in clock cycles
    localparam int unsigned WD_PULSE_CYC = 4;
    // supervisor states
    typedef enum logic [1:0] {
        RWSUP_ST_HOLD,
        RWSUP_ST_DELAY,
        RWSUP_ST_WAKE_DLY,
        RWSUP_ST_RUN
    } rwsup_state_t;
endpackage

// ### rtl/rwsup_edge_det.sv
// module: synchroniser with falling-edge detector for one input
`timescale 1ns/10ps
`default_nettype none
module rwsup_edge_det (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic din,
    output logic level,
    output logic fall
);
    // ************************************************************
    // two-stage synchroniser, then edge detect on the second stage
    // ************************************************************
    logic s1_q;
    logic s2_q;
    logic s3_q;
    // first stage only feeds the second, never logic
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign level = s2_q;
    assign fall = s3_q & ~s2_q;
endmodule
`default_nettype wire

// ### tb/rwsup_mcu_model.sv
// controller model: answers each wakeup rise with one or two watchdog kicks
`timescale 1ns/10ps
`default_nettype none
module rwsup_mcu_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic wakeup,
    input wire logic kick_en,
    input wire logic [7:0] kick_dly,
    input wire logic dbl_kick,
    output logic watchdog_kick_input
);
    logic wake_prev_q = 1'b0;
    int cnt_q = -1;
    int d;
    logic low_now;
    // pulses last 3 cycles so the two-flop synchroniser always catches them
    assign d = int'(kick_dly);
    assign low_now = (cnt_q >= d && cnt_q < d + 3) || (dbl_kick && cnt_q >= d + 8 && cnt_q < d + 11);
    initial watchdog_kick_input = 1'b1;
    // the kick line idles high, so only a deliberate falling edge is seen
    always @(posedge clk_sys) begin
        wake_prev_q <= wakeup;
        if (!reset_n || (wakeup && !wake_prev_q)) begin
            cnt_q <= (reset_n && kick_en) ? 0 : -1;
            watchdog_kick_input <= 1'b1;
        end else if (cnt_q >= 0) begin
            cnt_q <= (cnt_q > d + 12) ? -1 : cnt_q + 1;
            watchdog_kick_input <= !low_now;
        end
    end
endmodule
`default_nettype wire

// ### tb/rwsup_tb_top.sv
// testbench: supervisor with a controller model on its far side
`timescale 1ns/10ps
`default_nettype none
module rwsup_tb_top;
    // ****************************************
    // short period keeps the run brief
    // ****************************************
    localparam logic [31:0] PER = 32'h40;
    localparam int P = int'(PER);
    localparam int HALF = P / 2;
    localparam int DLY = P / 8 + 1;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic enable = 1'b1;
    logic supply_input_ok = 1'b1;
    logic regulated_output_ok = 1'b0;
    logic kick_en = 1'b1;
    logic dbl_kick = 1'b0;
    logic [7:0] kick_dly = 8'h28;
    logic reset_n, wakeup, regulator_on, watchdog_kick_input;
    int error_cnt = 0;
    int comparisons = 0;
    int n, m, d;
    bit early;
    always #12.5 clk_sys = ~clk_sys;
    rwsup_top #(.PERIOD_CYC(PER)) i_rwsup_top (.clk_sys(clk_sys), .rst(rst), .enable(enable),
        .supply_input_ok(supply_input_ok), .regulated_output_ok(regulated_output_ok),
        .watchdog_kick_input(watchdog_kick_input), .reset_n(reset_n), .wakeup(wakeup),
        .regulator_on(regulator_on));
    rwsup_mcu_model i_rwsup_mcu_model (.clk_sys(clk_sys), .reset_n(reset_n), .wakeup(wakeup),
        .kick_en(kick_en), .kick_dly(kick_dly), .dbl_kick(dbl_kick),
        .watchdog_kick_input(watchdog_kick_input));
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cmp_range(input string what, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? reset_n : (s == 1 ? wakeup : regulator_on);
    endfunction
    // one cycle; outputs are settled 2 ns after the edge, inputs change there too
    task automatic tick();
        @(posedge clk_sys);
        #2;
        if (reset_n === 1'b0)
            cmp_bit("wakeup in reset", 1'b0, wakeup);
    endtask
    // bounded wait; cnt is the number of cycles it took
    task automatic wait_lvl(input int s, input logic val, input int max, output int cnt);
        cnt = 0;
        while (pick(s) !== val) begin
            tick();
            cnt++;
            if (cnt > max) begin
                error_cnt++;
                $display("mismatch wait on output %0d expected %b seen %b", s, val, pick(s));
                print_verdict();
            end
        end
    endtask
    initial begin
        void'($urandom(32'he31b));
        repeat (3) tick();
        cmp_bit("reset_n in rst", 1'b0, reset_n);
        rst = 1'b0;
        repeat (40) tick();
        cmp_bit("reset_n power-up", 1'b0, reset_n);
        regulated_output_ok = 1'b1;
        wait_lvl(0, 1'b1, 30, n);
        cmp_range("power-up delay", DLY + 2, DLY + 6, n);
        cmp_bit("regulator_on", 1'b1, regulator_on);
        wait_lvl(1, 1'b1, P, n);
        cmp_range("reset to wakeup", HALF, HALF + 2, n);
        // early kicks cut the high phase short, late ones leave it whole
        for (int i = 0; i < 8; i++) begin
            early = i[0];
            dbl_kick = 1'($urandom_range(1));
            d = early ? int'($urandom_range(8, 2)) : HALF + int'($urandom_range(8, 2));
            kick_dly = 8'(d);
            wait_lvl(1, 1'b0, P, n);
            if (early)
                cmp_range("kick to wakeup low", d + 3, d + 8, n);
            else
                cmp_range("wakeup high time", HALF, HALF, n);
            wait_lvl(1, 1'b1, P, m);
            cmp_range("wakeup period", P, P, n + m);
            cmp_bit("reset_n after kicks", 1'b1, reset_n);
        end
        kick_en = 1'b0;
        wait_lvl(0, 1'b0, P + 8, n);
        cmp_range("missed kick reset", P - 2, P + 3, n);
        wait_lvl(0, 1'b1, 40, n);
        cmp_range("kick reset length", rwsup_pkg::WD_PULSE_CYC + DLY, rwsup_pkg::WD_PULSE_CYC + DLY + 2, n);
        kick_en = 1'b1;
        wait_lvl(1, 1'b1, P, n);
        cmp_range("restart delay", HALF, HALF + 2, n);
        supply_input_ok = 1'b0;
        wait_lvl(0, 1'b0, 6, n);
        cmp_range("supply fail", 1, 5, n);
        supply_input_ok = 1'b1;
        wait_lvl(0, 1'b1, 40, n);
        regulated_output_ok = 1'b0;
        repeat ($urandom_range(20, 6)) tick();
        cmp_bit("reset_n output low", 1'b0, reset_n);
        regulated_output_ok = 1'b1;
        wait_lvl(0, 1'b1, 40, n);
        cmp_range("recovery delay", DLY + 2, DLY + 6, n);
        enable = 1'b0;
        wait_lvl(2, 1'b0, 6, n);
        cmp_range("regulator off", 2, 5, n);
        wait_lvl(0, 1'b0, 6, n);
        cmp_range("reset on disable", 0, 3, n);
        enable = 1'b1;
        wait_lvl(2, 1'b1, 6, n);
        cmp_range("regulator back on", 2, 5, n);
        wait_lvl(0, 1'b1, 40, n);
        // regulator_on already took the synchroniser cycles off this count
        cmp_range("enable recovery", DLY - 1, DLY + 3, n);
        print_verdict();
    end
endmodule
`default_nettype wire
